// ==== pss_defs.svh ====
`ifndef PSS_DEFS_SVH
`define PSS_DEFS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PSS_OFF_HW_CONFIG 8'h00
`define PSS_OFF_POWER_CTRL 8'h04
`define PSS_OFF_IRQ_STATUS 8'h08
`define PSS_OFF_WAKE_TEST 8'h0c
`define PSS_OFF_PHY_BASIC_CTRL 8'h10
`define PSS_OFF_PHY_MODE_CTRL 8'h14
`define PSS_OFF_PHY_BASIC_STAT 8'h18
`define PSS_OFF_PHY_IRQ_SRC 8'h1c
`define PSS_OFF_EEPROM_CMD 8'h20
// ----------------------------------------
// field positions
// ----------------------------------------
`define PSS_BIT_SOFT_RESET 0
`define PSS_BIT_READY 0
`define PSS_BIT_PIN_EN 1
`define PSS_BIT_PULSE_SEL 3
`define PSS_BIT_FRAME_WAKE_EN 8
`define PSS_BIT_ENERGY_WAKE_EN 9
`define PSS_BIT_PHY_RESET 10
`define PSS_LSB_POWER_STATE 12
`define PSS_LSB_WAKE_SRC 16
`define PSS_BIT_WAKE_IRQ 17
`define PSS_BIT_PHY_SOFT_RESET 15
`define PSS_BIT_PHY_POWERDOWN 11
`define PSS_BIT_ED_POWERDOWN 13
`define PSS_BIT_ENERGY_ON 1
`define PSS_BIT_LINK_UP 2
`define PSS_BIT_PHY_ENERGY_IRQ 1
`define PSS_BIT_EEPROM_BUSY 31
// ----------------------------------------
// encodings and reset values
// ----------------------------------------
`define PSS_PS_D0 2'h0
`define PSS_PS_D1 2'h1
`define PSS_PS_D2 2'h2
`define PSS_WS_ENERGY 2'h1
`define PSS_WS_FRAME 2'h2
`define PSS_RST_ZERO 32'h0
// ----------------------------------------
// timing
// ----------------------------------------
`define PSS_CLK_MHZ 250
`define PSS_POR_TIME_US 22000
`define PSS_PULSE_TIME_US 50000
`define PSS_RESUME_TIME_US 2000
`define PSS_SOFT_RESET_BIT_TIME_NS 2000
`define PSS_PHYRST_TIME_US 100
`endif

// ==== pss_pkg.sv ====
`default_nettype none
package pss_pkg;
	// sequencer states
	typedef enum logic [2:0] {PS_POR, PS_D0, PS_D1, PS_D2, PS_WAKE, PS_SOFT_RESET_BIT} pss_state_t;
	// one register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} pss_bus_req_t;
	// clock enables for gated domains
	typedef struct packed {
		logic mac;
		logic host_bus_interface;
		logic pm;
		logic intl;
	} pss_clk_en_t;
endpackage
`default_nettype wire

// ==== pss_top.sv ====
// The address map and the address-and-strobe port are this design's own decisions.
`include "pss_defs.svh"
`default_nettype none
// Notes on behaviour
// - power state 10b enters deep sleep, ready clears
// - deep sleep gates mac, bus, pm, internal clocks
// - carrier in deep sleep sets wake source 01b
// - wake irq status set regardless of pin enable
// - wake test write returns to D0
// - wake irq sticky while source persists, w1c
// - pulse select gives 50ms pulse, else static
// - wake pin drops when source or enables clear
// - phy powerdown bit holds phy down, reset on clear
// - energy powerdown sleeps phy, flags energy arrival
// - five reset sources, soft reset spares exempt bits
// - eeprom probe after hard/soft reset, busy bit
// - power-on timer 22ms holds ready low
// - reset pin low gives full reset
// - ready sets within 2ms after wake write
// - soft reset bit self-clears after 2us
// - phy reset bit self-clears after 100us
// - phy basic reset bit self-clears when done
// - power state 01 enters light sleep, ready clears
// - wake frame in light sleep sets source 10b
module pss_top
	import pss_pkg::*;
#(
	parameter int POR_CYCLES = `PSS_POR_TIME_US * `PSS_CLK_MHZ, // power-on hold
	parameter int PULSE_CYCLES = `PSS_PULSE_TIME_US * `PSS_CLK_MHZ, // wake pin pulse
	parameter int RESUME_CYCLES = `PSS_RESUME_TIME_US * `PSS_CLK_MHZ, // wake to ready
	parameter int PHYRST_CYCLES = `PSS_PHYRST_TIME_US * `PSS_CLK_MHZ // phy reset
)
(
	input wire logic SYS_CLK, // always-on clock
	input wire logic RSTN, // reset_in_n pin, async low
	input wire pss_bus_req_t BUS_REQ, // register bus request
	output logic [31:0] BUS_RDATA, // read data, cycle after read
	input wire logic LINE_ENERGY_PIN, // line_energy_present from line
	input wire logic LINK_UP_PIN, // phy link status, async
	input wire logic FRAME_WAKE_DET, // wake frame or magic packet seen
	input wire logic EEPROM_BUSY, // eeprom engine busy
	output logic WAKE_OUT, // wake event pin, high active
	output pss_clk_en_t CLK_EN, // clock enables per domain
	output logic MAC_RESET, // internal reset of mac side
	output logic PHY_RESET, // phy reset in progress
	output logic PHY_PWRDN, // phy general powerdown
	output logic PHY_SLEEP, // phy powered down, no energy
	output logic EEPROM_PROBE // one-cycle eeprom probe start
);
	// ----------------------------------------
	// timing counts
	// ----------------------------------------
	localparam int SOFT_RESET_BIT_CYCLES = (`PSS_SOFT_RESET_BIT_TIME_NS * `PSS_CLK_MHZ + 999) / 1000;

	// set beats clear for every sticky flag
	function automatic logic sticky(input logic q, input logic set, input logic clr);
		sticky = set | (q & ~clr);
	endfunction

	// true on the last cycle of a timed interval
	function automatic logic cnt_done(input logic [23:0] cnt, input int lim);
		cnt_done = (cnt >= 24'(lim - 1));
	endfunction

	// ----------------------------------------
	// reset and input synchronisers
	// ----------------------------------------
	logic rst_meta_q; // first reset stage
	logic rst_n; // released reset
	logic [1:0] energy_sync_q; // energy pin stages
	logic [1:0] link_sync_q; // link pin stages
	logic energy_prev_q; // energy, previous cycle

	// reset released through two stages; the pin is a full reset
	always_ff @(posedge SYS_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	// pin levels pass two stages before use
	always_ff @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			energy_sync_q <= 2'h0;
			link_sync_q <= 2'h0;
			energy_prev_q <= 1'b0;
		end
		else
		begin
			energy_sync_q <= {energy_sync_q[0], LINE_ENERGY_PIN};
			link_sync_q <= {link_sync_q[0], LINK_UP_PIN};
			energy_prev_q <= energy_sync_q[1];
		end
	end

	wire energy_on = energy_sync_q[1]; // synced line energy
	wire link_up = link_sync_q[1]; // synced link status

	// ----------------------------------------
	// state and storage
	// ----------------------------------------
	pss_state_t state_q, state_d; // sequencer
	logic [23:0] seq_cnt_q, seq_cnt_d; // sequencer timer
	logic ready_q; // ready bit
	logic pin_en_q; // wake pin enable
	logic pulse_sel_q; // wake_pin_pulse_select
	logic frame_wake_en_q; // frame_wake_enable
	logic energy_wake_en_q; // energy_wake_enable
	logic [1:0] wake_src_q, wake_src_d; // wake_source_status
	logic wake_irq_q, wake_irq_d; // wake irq status bit
	logic wake_src_pend_q; // wake source, previous cycle
	logic [23:0] pulse_cnt_q, pulse_cnt_d; // wake pulse timer
	logic phy_pd_q; // phy powerdown bit
	logic edpd_q; // energy_detect_powerdown
	logic phy_eirq_q, phy_eirq_d; // phy energy flag
	logic [23:0] phy_cnt_q, phy_cnt_d; // phy reset timer
	logic phyrst_pc_q, phyrst_pc_d; // power control phy reset bit
	logic phyrst_bc_q, phyrst_bc_d; // basic control reset bit
	logic [31:0] rd_mux; // read selection

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	wire awake = (state_q == PS_D0); // full access only when ready
	wire asleep = (state_q == PS_D1) || (state_q == PS_D2);
	wire [31:0] wd = BUS_REQ.wdata; // write data
	wire wr_hw = BUS_REQ.wr && (BUS_REQ.addr == `PSS_OFF_HW_CONFIG) && awake;
	wire wr_pc = BUS_REQ.wr && (BUS_REQ.addr == `PSS_OFF_POWER_CTRL) && awake;
	wire wr_irq = BUS_REQ.wr && (BUS_REQ.addr == `PSS_OFF_IRQ_STATUS) && awake;
	wire wr_bc = BUS_REQ.wr && (BUS_REQ.addr == `PSS_OFF_PHY_BASIC_CTRL) && awake;
	wire wr_mc = BUS_REQ.wr && (BUS_REQ.addr == `PSS_OFF_PHY_MODE_CTRL) && awake;
	wire wr_pis = BUS_REQ.wr && (BUS_REQ.addr == `PSS_OFF_PHY_IRQ_SRC) && awake;
	// sleep writes other than this are dropped; decode sits on the always-on clock
	wire wr_wake = BUS_REQ.wr && (BUS_REQ.addr == `PSS_OFF_WAKE_TEST) && asleep;
	wire [1:0] ps_wr = wd[`PSS_LSB_POWER_STATE +: 2]; // requested power state
	wire soft_reset_bit_req = wr_hw && wd[`PSS_BIT_SOFT_RESET];
	wire in_soft_reset_bit = (state_q == PS_SOFT_RESET_BIT);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	// timed states leave on their counter; sleep only leaves on the wake write
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			PS_POR:
			begin
				if (cnt_done(seq_cnt_q, POR_CYCLES))
					state_d = PS_D0;
			end
			PS_D0:
			begin
				if (soft_reset_bit_req)
					state_d = PS_SOFT_RESET_BIT;
				else if (wr_pc && ps_wr == `PSS_PS_D1)
					state_d = PS_D1;
				else if (wr_pc && ps_wr == `PSS_PS_D2)
					state_d = PS_D2;
			end
			PS_D1, PS_D2:
			begin
				if (wr_wake)
					state_d = PS_WAKE;
			end
			PS_WAKE:
			begin
				if (cnt_done(seq_cnt_q, RESUME_CYCLES))
					state_d = PS_D0;
			end
			PS_SOFT_RESET_BIT:
			begin
				if (cnt_done(seq_cnt_q, SOFT_RESET_BIT_CYCLES))
					state_d = PS_D0;
			end
			default:
				state_d = PS_POR;
		endcase
	end

	// timer restarts on each state change
	assign seq_cnt_d = (state_d != state_q) ? 24'h0 : seq_cnt_q + 24'h1;

	// sequencer registers; ready follows the next state so it reads true in D0
	always_ff @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= PS_POR;
			seq_cnt_q <= 24'h0;
			ready_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			seq_cnt_q <= seq_cnt_d;
			ready_q <= (state_d == PS_D0);
		end
	end

	// ----------------------------------------
	// wake detection and wake irq
	// ----------------------------------------
	// carrier already present on entry counts at once
	wire set_energy = (state_q == PS_D2) && energy_on;
	wire set_frame = (state_q == PS_D1) && FRAME_WAKE_DET;
	wire [1:0] ws_clr = wr_pc ? wd[`PSS_LSB_WAKE_SRC +: 2] : 2'h0; // write one clears

	assign wake_src_d[0] = sticky(wake_src_q[0], set_energy, ws_clr[0] | in_soft_reset_bit);
	assign wake_src_d[1] = sticky(wake_src_q[1], set_frame, ws_clr[1] | in_soft_reset_bit);

	// internal wake interrupt: source gated by its enable
	wire wake_src_pend = (wake_src_q[0] && energy_wake_en_q) ||
		(wake_src_q[1] && frame_wake_en_q);
	// status can only be cleared once the source has gone
	wire irq_clr = wr_irq && wd[`PSS_BIT_WAKE_IRQ] && !wake_src_pend;
	assign wake_irq_d = sticky(wake_irq_q, wake_src_pend, irq_clr | in_soft_reset_bit);

	// ----------------------------------------
	// wake pin
	// ----------------------------------------
	wire pend_rise = wake_src_pend && !wake_src_pend_q; // new wake event
	assign pulse_cnt_d = !wake_src_pend ? 24'h0 :
		pend_rise ? 24'(PULSE_CYCLES - 1) :
		(pulse_cnt_q != 24'h0) ? pulse_cnt_q - 24'h1 : 24'h0;
	wire pulse_on = pend_rise || (pulse_cnt_q != 24'h0); // pulse window
	// pin drops as soon as source, its enable or the pin enable goes
	wire wake_pin_d = pin_en_q && wake_src_pend && (!pulse_sel_q || pulse_on);

	// ----------------------------------------
	// phy powerdown and reset
	// ----------------------------------------
	wire bc_rst_wr = wr_bc && wd[`PSS_BIT_PHY_SOFT_RESET];
	wire pc_rst_wr = wr_pc && wd[`PSS_BIT_PHY_RESET];
	// clearing the powerdown bit resets the phy as it powers up
	wire pd_release = wr_bc && phy_pd_q && !wd[`PSS_BIT_PHY_POWERDOWN];
	wire phy_start = bc_rst_wr || pc_rst_wr || pd_release || (state_q == PS_POR);
	assign phy_cnt_d = phy_start ? 24'(PHYRST_CYCLES) :
		(phy_cnt_q != 24'h0) ? phy_cnt_q - 24'h1 : 24'h0;
	wire phy_busy = (phy_cnt_d != 24'h0); // reset still running
	assign phyrst_pc_d = (pc_rst_wr || phyrst_pc_q) && phy_busy;
	assign phyrst_bc_d = (bc_rst_wr || phyrst_bc_q) && phy_busy;
	// energy arrival flag while energy powerdown is armed
	wire energy_rise = edpd_q && energy_on && !energy_prev_q;
	wire eirq_clr = wr_pis && wd[`PSS_BIT_PHY_ENERGY_IRQ];
	assign phy_eirq_d = sticky(phy_eirq_q, energy_rise, eirq_clr);

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	// enables are soft-reset-exempt; sticky flags are cleared by soft reset
	always_ff @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_en_q <= 1'b0;
			pulse_sel_q <= 1'b0;
			frame_wake_en_q <= 1'b0;
			energy_wake_en_q <= 1'b0;
			wake_src_q <= 2'h0;
			wake_irq_q <= 1'b0;
			wake_src_pend_q <= 1'b0;
			pulse_cnt_q <= 24'h0;
		end
		else
		begin
			if (wr_pc)
			begin
				pin_en_q <= wd[`PSS_BIT_PIN_EN];
				pulse_sel_q <= wd[`PSS_BIT_PULSE_SEL];
				frame_wake_en_q <= wd[`PSS_BIT_FRAME_WAKE_EN];
				energy_wake_en_q <= wd[`PSS_BIT_ENERGY_WAKE_EN];
			end
			wake_src_q <= wake_src_d;
			wake_irq_q <= wake_irq_d;
			wake_src_pend_q <= wake_src_pend;
			pulse_cnt_q <= pulse_cnt_d;
		end
	end

	// phy side registers, untouched by soft reset
	always_ff @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phy_pd_q <= 1'b0;
			edpd_q <= 1'b0;
			phy_eirq_q <= 1'b0;
			phy_cnt_q <= 24'h0;
			phyrst_pc_q <= 1'b0;
			phyrst_bc_q <= 1'b0;
		end
		else
		begin
			if (wr_bc)
				phy_pd_q <= wd[`PSS_BIT_PHY_POWERDOWN];
			if (wr_mc)
				edpd_q <= wd[`PSS_BIT_ED_POWERDOWN];
			phy_eirq_q <= phy_eirq_d;
			phy_cnt_q <= phy_cnt_d;
			phyrst_pc_q <= phyrst_pc_d;
			phyrst_bc_q <= phyrst_bc_d;
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	wire [1:0] ps_rd = (state_q == PS_D1) ? `PSS_PS_D1 :
		(state_q == PS_D2) ? `PSS_PS_D2 : `PSS_PS_D0; // field reads 00 after wake
	wire [31:0] pc_word = {14'h0, wake_src_q, 2'h0, ps_rd, 1'b0, phyrst_pc_q,
		energy_wake_en_q, frame_wake_en_q, 4'h0, pulse_sel_q, 1'b0, pin_en_q,
		ready_q};

	// while asleep only power control answers, everything else reads zero
	always_comb
	begin
		rd_mux = `PSS_RST_ZERO;
		case (BUS_REQ.addr)
			`PSS_OFF_POWER_CTRL:
				rd_mux = pc_word;
			`PSS_OFF_HW_CONFIG:
				rd_mux = {31'h0, in_soft_reset_bit};
			`PSS_OFF_IRQ_STATUS:
				rd_mux = {14'h0, wake_irq_q, 17'h0};
			`PSS_OFF_PHY_BASIC_CTRL:
				rd_mux = {16'h0, phyrst_bc_q, 3'h0, phy_pd_q, 11'h0};
			`PSS_OFF_PHY_MODE_CTRL:
				rd_mux = {18'h0, edpd_q, 11'h0, energy_on, 1'b0};
			`PSS_OFF_PHY_BASIC_STAT:
				rd_mux = {29'h0, link_up, 2'h0};
			`PSS_OFF_PHY_IRQ_SRC:
				rd_mux = {30'h0, phy_eirq_q, 1'b0};
			`PSS_OFF_EEPROM_CMD:
				rd_mux = {EEPROM_BUSY, 31'h0};
			default:
				rd_mux = `PSS_RST_ZERO;
		endcase
		if (!awake && BUS_REQ.addr != `PSS_OFF_POWER_CTRL)
			rd_mux = `PSS_RST_ZERO;
	end

	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	wire pwr_ok = (state_d == PS_D0) || (state_d == PS_WAKE); // clocks up while resuming

	// every output leaves a flop; read data stand one cycle only
	always_ff @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			BUS_RDATA <= `PSS_RST_ZERO;
			WAKE_OUT <= 1'b0;
			CLK_EN <= '0;
			MAC_RESET <= 1'b1;
			PHY_RESET <= 1'b1;
			PHY_PWRDN <= 1'b0;
			PHY_SLEEP <= 1'b0;
			EEPROM_PROBE <= 1'b0;
		end
		else
		begin
			BUS_RDATA <= BUS_REQ.rd ? rd_mux : `PSS_RST_ZERO;
			WAKE_OUT <= wake_pin_d;
			CLK_EN.mac <= pwr_ok;
			CLK_EN.host_bus_interface <= pwr_ok || (state_d == PS_SOFT_RESET_BIT);
			CLK_EN.pm <= pwr_ok || (state_d == PS_D1);
			CLK_EN.intl <= (state_d != PS_D2);
			MAC_RESET <= (state_d == PS_POR) || (state_d == PS_SOFT_RESET_BIT);
			PHY_RESET <= phy_busy;
			PHY_PWRDN <= phy_pd_q;
			PHY_SLEEP <= edpd_q && !energy_on;
			EEPROM_PROBE <= ((state_q == PS_POR) || in_soft_reset_bit) && (state_d == PS_D0);
		end
	end
endmodule
`default_nettype wire

// ==== pss_top_sva.sv ====
`include "pss_defs.svh"
`default_nettype none
module pss_top_sva
	import pss_pkg::*;
#(
	parameter int POR_CYCLES = 20, // power-on hold
	parameter int PHYRST_CYCLES = 15 // phy reset run
)
(
	input wire logic SYS_CLK, // clock
	input wire logic RSTN, // async reset
	input wire pss_bus_req_t BUS_REQ, // bus request
	input wire logic [31:0] BUS_RDATA, // read data
	input wire logic LINE_ENERGY_PIN, // line energy
	input wire pss_clk_en_t CLK_EN, // clock enables
	input wire logic MAC_RESET, // mac reset
	input wire logic PHY_RESET, // phy reset
	input wire logic PHY_SLEEP, // phy asleep
	input wire logic EEPROM_PROBE // probe pulse
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);
	// ----------------------------------------
	// helper counters
	// ----------------------------------------
	int por_cnt; // cycles since release, saturating
	int mr_cnt; // run length of mac reset
	int pr_cnt; // run length of phy reset
	logic por_done; // power-on sequence long over
	logic ps_wr; // power state write while ready
	logic wk_wr; // wake write while asleep
	// the phy reset started by power-on runs past the hold, so wait for it too
	assign por_done = por_cnt == POR_CYCLES + PHYRST_CYCLES + 8;
	assign ps_wr = BUS_REQ.wr && BUS_REQ.addr == `PSS_OFF_POWER_CTRL && CLK_EN == 4'hf && !MAC_RESET;
	assign wk_wr = BUS_REQ.wr && BUS_REQ.addr == `PSS_OFF_WAKE_TEST && !CLK_EN.host_bus_interface && !MAC_RESET
		&& por_done;
	// run lengths restart at every reset so a mid-run reset is judged afresh
	always_ff @(posedge SYS_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			por_cnt <= 0;
			mr_cnt <= 0;
			pr_cnt <= 0;
		end
		else
		begin
			por_cnt <= por_done ? por_cnt : por_cnt + 1;
			mr_cnt <= MAC_RESET ? mr_cnt + 1 : 0;
			pr_cnt <= PHY_RESET ? pr_cnt + 1 : 0;
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_rd_idle; !$past(BUS_REQ.rd) |-> BUS_RDATA == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside its slot");
	property p_d2; ps_wr && BUS_REQ.wdata[13:12] == `PSS_PS_D2 |-> ##2 CLK_EN == 4'h0; endproperty
	a_d2: assert property (p_d2)
		else $error("deep sleep left clocks running");
	property p_d1;
		ps_wr && BUS_REQ.wdata[13:12] == `PSS_PS_D1 |-> ##2 !CLK_EN.host_bus_interface && !CLK_EN.mac && CLK_EN.intl;
	endproperty
	a_d1: assert property (p_d1)
		else $error("light sleep clocks wrong");
	property p_wake; wk_wr |-> ##[1:2] CLK_EN == 4'hf; endproperty
	a_wake: assert property (p_wake)
		else $error("wake write did not restore clocks");
	property p_probe; EEPROM_PROBE |=> !EEPROM_PROBE && !MAC_RESET; endproperty
	a_probe: assert property (p_probe)
		else $error("probe pulse malformed");
	// every end of a power-on, pin or soft reset starts the eeprom probe
	property p_probe_end; $fell(MAC_RESET) |-> EEPROM_PROBE; endproperty
	a_probe_end: assert property (p_probe_end)
		else $error("reset ended without probe");
	// internal clock runs during the hold; first cycles still show the reset value
	property p_por_hold;
		por_cnt < POR_CYCLES |-> MAC_RESET && CLK_EN == (por_cnt < 3 ? 4'h0 : 4'h1);
	endproperty
	a_por_hold: assert property (p_por_hold)
		else $error("power-on hold too short");
	property p_por_end; por_cnt == POR_CYCLES + 6 |-> !MAC_RESET && CLK_EN == 4'hf; endproperty
	a_por_end: assert property (p_por_end)
		else $error("power-on hold too long");
	property p_soft_reset_bit_len; $fell(MAC_RESET) && por_done |-> mr_cnt inside {[498:502]}; endproperty
	a_soft_reset_bit_len: assert property (p_soft_reset_bit_len)
		else $error("soft reset length wrong");
	property p_phy_len;
		$fell(PHY_RESET) && por_done |-> pr_cnt inside {[PHYRST_CYCLES - 1:PHYRST_CYCLES + 2]};
	endproperty
	a_phy_len: assert property (p_phy_len)
		else $error("phy reset length wrong");
	property p_energy; por_done ##0 LINE_ENERGY_PIN [*4] |=> !PHY_SLEEP; endproperty
	a_energy: assert property (p_energy)
		else $error("phy asleep with energy on line");
	c_d2: cover property (ps_wr && BUS_REQ.wdata[13:12] == `PSS_PS_D2);
	c_wake: cover property (wk_wr);
	c_soft_reset_bit: cover property ($fell(MAC_RESET) && por_done);
endmodule
bind pss_top pss_top_sva #(.POR_CYCLES(POR_CYCLES), .PHYRST_CYCLES(PHYRST_CYCLES)) i_sva (
	.SYS_CLK(SYS_CLK),
	.RSTN(RSTN),
	.BUS_REQ(BUS_REQ),
	.BUS_RDATA(BUS_RDATA),
	.LINE_ENERGY_PIN(LINE_ENERGY_PIN),
	.CLK_EN(CLK_EN),
	.MAC_RESET(MAC_RESET),
	.PHY_RESET(PHY_RESET),
	.PHY_SLEEP(PHY_SLEEP),
	.EEPROM_PROBE(EEPROM_PROBE)
);
`default_nettype wire

// ==== pss_host_model.sv ====
`default_nettype none
module pss_host
	import pss_pkg::*;
(
	input wire logic clk, // bus clock
	input wire logic [31:0] rdata, // read data
	output pss_bus_req_t req // bus request
);
	timeunit 1ns;
	timeprecision 100ps;
	initial req = '0;
	// one-cycle write strobe; the caller only writes while ready, bar the wake write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		req <= '0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		req <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk);
		req <= '0;
		@(posedge clk);
		d = rdata;
	endtask
endmodule
`default_nettype wire

// ==== pss_top_tb.sv ====
`include "pss_defs.svh"
`default_nettype none
`define CHK(nm, ex, got) \
	begin tests_run++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("BAD %s exp %h got %h", nm, ex, got); end end
module pss_top_tb
	import pss_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int POR = 20; // shortened counts
	localparam int PULSE = 30;
	localparam int RESUME = 10;
	localparam int PHYRST = 15;
	typedef struct {logic [31:0] e; logic [31:0] m;} pss_note_t;
	logic sys_clk = 1'b0, rstn = 1'b0, energy = 1'b0, link = 1'b1, fdet = 1'b0, ebusy = 1'b1;
	logic wake, mac_rst, phy_rst, phy_pd, phy_sl, probe, rd_d = 1'b0;
	logic [31:0] rdata, seed = 32'h0000befd;
	pss_bus_req_t req;
	pss_clk_en_t clk_en;
	int n_mismatch = 0, tests_run = 0;
	int n_probe = 0; // eeprom probe pulses seen
	pss_note_t q[$]; // expected read results, oldest first
	pss_note_t nt;
	always #2 sys_clk = ~sys_clk;
	pss_top #(.POR_CYCLES(POR), .PULSE_CYCLES(PULSE), .RESUME_CYCLES(RESUME),
		.PHYRST_CYCLES(PHYRST)) i_dut (.SYS_CLK(sys_clk), .RSTN(rstn), .BUS_REQ(req),
		.BUS_RDATA(rdata), .LINE_ENERGY_PIN(energy), .LINK_UP_PIN(link), .FRAME_WAKE_DET(fdet),
		.EEPROM_BUSY(ebusy), .WAKE_OUT(wake), .CLK_EN(clk_en), .MAC_RESET(mac_rst),
		.PHY_RESET(phy_rst), .PHY_PWRDN(phy_pd), .PHY_SLEEP(phy_sl), .EEPROM_PROBE(probe));
	pss_host i_host (.clk(sys_clk), .rdata(rdata), .req(req));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// monitor: each read slot takes the oldest note; mask zero means a poll
	always @(posedge sys_clk)
	begin
		if (rd_d && q.size() > 0)
		begin
			nt = q.pop_front();
			if (nt.m != 32'h0) `CHK("rdata", nt.e & nt.m, rdata & nt.m)
		end
		if (probe)
			n_probe++;
		rd_d <= req.rd;
	end
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		logic [31:0] d;
		q.push_back('{e, m});
		i_host.rd(a, d);
	endtask
	// ready poll, bounded; running out is a mismatch
	task automatic poll(input int n);
		logic [31:0] d;
		int i;
		d = 32'h0;
		for (i = 0; i < n && d[0] !== 1'b1; i++)
		begin
			q.push_back('{32'h0, 32'h0});
			i_host.rd(`PSS_OFF_POWER_CTRL, d);
		end
		if (d[0] !== 1'b1)
		begin
			n_mismatch++;
			$display("BAD ready exp 1 got %h", d[0]);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		tick(50000);
		n_mismatch++;
		$display("BAD watchdog exp done got hang");
		test_done();
	end
	initial
	begin
		logic [31:0] cfg;
		logic [7:0] a;
		int k;
		tick(8);
		rstn <= 1'b1;
		poll(POR);
		rchk(`PSS_OFF_PHY_BASIC_STAT, 32'h4, 32'h4);
		link <= 1'b0;
		tick(3);
		rchk(`PSS_OFF_PHY_BASIC_STAT, 32'h0, 32'h4);
		link <= 1'b1;
		rchk(`PSS_OFF_EEPROM_CMD, 32'h80000000, 32'h80000000);
		ebusy <= 1'b0;
		rchk(`PSS_OFF_EEPROM_CMD, 32'h0, 32'h80000000);
		i_host.wr(8'h3c, xs());
		rchk(8'h3c, 32'h0, 32'hffffffff);
		// both phy reset bits self-clear after the reset run
		for (k = 0; k < 2; k++)
		begin
			a = k ? `PSS_OFF_PHY_BASIC_CTRL : `PSS_OFF_POWER_CTRL;
			cfg = k ? 32'h8000 : 32'h400;
			i_host.wr(a, cfg);
			rchk(a, cfg, cfg);
			tick(PHYRST + 5);
			rchk(a, 32'h0, cfg);
		end
		i_host.wr(`PSS_OFF_PHY_BASIC_CTRL, 32'h800);
		tick(3);
		`CHK("phy_pwrdn", 1'b1, phy_pd)
		i_host.wr(`PSS_OFF_PHY_BASIC_CTRL, 32'h0);
		tick(3);
		`CHK("phy_reset", 1'b1, phy_rst)
		tick(PHYRST + 5);
		// soft reset keeps the enables
		i_host.wr(`PSS_OFF_POWER_CTRL, 32'h202);
		i_host.wr(`PSS_OFF_HW_CONFIG, 32'h1);
		rchk(`PSS_OFF_POWER_CTRL, 32'h0, 32'h1);
		`CHK("mac_reset", 1'b1, mac_rst)
		poll(200);
		rchk(`PSS_OFF_HW_CONFIG, 32'h0, 32'h1);
		rchk(`PSS_OFF_POWER_CTRL, 32'h203, 32'h203);
		// deep sleep: static pin, pin off with carrier at entry, pulsed pin
		for (k = 0; k < 3; k++)
		begin
			cfg = 32'h200 | (k != 1 ? 32'h2 : 32'h0) | (k == 2 ? 32'h8 : 32'h0);
			energy <= (k == 1);
			i_host.wr(`PSS_OFF_PHY_MODE_CTRL, 32'h2000);
			i_host.wr(`PSS_OFF_POWER_CTRL, cfg | 32'h2000);
			tick(3);
			`CHK("clk_en", 4'h0, clk_en)
			if (k != 1) `CHK("phy_sleep", 1'b1, phy_sl)
			energy <= 1'b1;
			tick(8);
			`CHK("wake_out", (k != 1), wake)
			rchk(`PSS_OFF_POWER_CTRL, 32'h10000, 32'h30001);
			tick(PULSE + 4);
			`CHK("wake_out", (k == 0), wake)
			i_host.wr(`PSS_OFF_WAKE_TEST, xs());
			poll(RESUME / 3 + 3);
			rchk(`PSS_OFF_POWER_CTRL, 32'h1, 32'h3001);
			// energy arrival flag only on a fresh rise while armed
			rchk(`PSS_OFF_PHY_IRQ_SRC, (k != 1) ? 32'h2 : 32'h0, 32'h2);
			i_host.wr(`PSS_OFF_PHY_IRQ_SRC, 32'h2);
			i_host.wr(`PSS_OFF_PHY_MODE_CTRL, 32'h0);
			rchk(`PSS_OFF_IRQ_STATUS, 32'h20000, 32'h20000);
			i_host.wr(`PSS_OFF_IRQ_STATUS, 32'h20000);
			rchk(`PSS_OFF_IRQ_STATUS, 32'h20000, 32'h20000);
			i_host.wr(`PSS_OFF_POWER_CTRL, cfg | 32'h30000);
			tick(3);
			`CHK("wake_out", 1'b0, wake)
			i_host.wr(`PSS_OFF_IRQ_STATUS, 32'h20000);
			rchk(`PSS_OFF_IRQ_STATUS, 32'h0, 32'h20000);
		end
		// light sleep, woken by a frame
		i_host.wr(`PSS_OFF_POWER_CTRL, 32'h1102);
		tick(3);
		`CHK("clk_intl", 1'b1, clk_en.intl)
		fdet <= 1'b1;
		tick(1);
		fdet <= 1'b0;
		tick(6);
		rchk(`PSS_OFF_POWER_CTRL, 32'h20000, 32'h30001);
		`CHK("wake_out", 1'b1, wake)
		i_host.wr(`PSS_OFF_WAKE_TEST, xs());
		poll(RESUME / 3 + 3);
		i_host.wr(`PSS_OFF_POWER_CTRL, 32'h30102);
		// reset pin in mid-run
		rstn <= 1'b0;
		tick(3);
		rstn <= 1'b1;
		rchk(`PSS_OFF_POWER_CTRL, 32'h0, 32'h1);
		poll(POR);
		`CHK("probes", 3, n_probe)
		test_done();
	end
endmodule
`default_nettype wire
